// ### core/cifd_consts.vh
// Constants shared by the instruction format decoder files
`ifndef CIFD_CONSTS_VH
`define CIFD_CONSTS_VH

// ****************************************
// Operand format codes (from predecode)
// ****************************************
`define CIFD_FMT_ZERO   4'h0
`define CIFD_FMT_N      4'h1
`define CIFD_FMT_M      4'h2
`define CIFD_FMT_NM     4'h3
`define CIFD_FMT_MD     4'h4
`define CIFD_FMT_ND4    4'h5
`define CIFD_FMT_NMD    4'h6
`define CIFD_FMT_D      4'h7
`define CIFD_FMT_D12    4'h8
`define CIFD_FMT_ND8    4'h9
`define CIFD_FMT_I      4'ha
`define CIFD_FMT_NI     4'hb

// ****************************************
// Operand addressing modes
// ****************************************
`define CIFD_AM_NONE    4'h0
`define CIFD_AM_DIRECT  4'h1
`define CIFD_AM_IND     4'h2
`define CIFD_AM_POSTINC 4'h3
`define CIFD_AM_PREDEC  4'h4
`define CIFD_AM_IDX_R0  4'h5
`define CIFD_AM_DISP    4'h6
`define CIFD_AM_GBR_DSP 4'h7
`define CIFD_AM_GBR_R0  4'h8
`define CIFD_AM_PC_DISP 4'h9
`define CIFD_AM_PC_REL  4'ha
`define CIFD_AM_CTRL    4'hb
`define CIFD_AM_IMM     4'hc
`define CIFD_AM_MAC     4'hd

// ****************************************
// Access sizes and field widths
// ****************************************
`define CIFD_SZ_BYTE    2'h0
`define CIFD_SZ_WORD    2'h1
`define CIFD_SZ_LONG    2'h2
`define CIFD_W4         2'h0
`define CIFD_W8         2'h1
`define CIFD_W12        2'h2
`define CIFD_SH_BRANCH  2'h1
`define CIFD_SH_TRAP    2'h2

// ****************************************
// Field positions and fixed indices
// ****************************************
`define CIFD_HI_LSB     8
`define CIFD_MID_LSB    4
`define CIFD_REG_ZERO   4'h0
`define CIFD_MASK_NONE  16'hffff
`define CIFD_MASK_HI    16'hf0ff
`define CIFD_MASK_MID   16'hff0f
`define CIFD_MASK_HIMID 16'hf00f
`define CIFD_MASK_LO8   16'hff00
`define CIFD_MASK_MIDLO 16'hff00
`define CIFD_MASK_ALL12 16'hf000
`define CIFD_MASK_HILO  16'hf000

// ****************************************
// Reset values
// ****************************************
`define CIFD_RST_WORD   16'h0000
`define CIFD_RST_VAL    32'h0000_0000

`endif

// ### core/cifd_ext.v
// Field extender: zero or sign extension followed by a left scale
`timescale 1ns/1ps

module cifd_ext (
  // Raw field and how to treat it
  input  wire [11:0] field,
  input  wire [1:0]  width,
  input  wire        sgn,
  input  wire [1:0]  shift,
  // Extended and scaled result
  output reg  [31:0] value
);
`include "cifd_consts.vh"

  reg [31:0] base;

  always @* begin
    case (width)
      `CIFD_W4: begin
        base = sgn ? {{28{field[3]}}, field[3:0]} : {28'h0000000, field[3:0]};
      end
      `CIFD_W8: begin
        base = sgn ? {{24{field[7]}}, field[7:0]} : {24'h000000, field[7:0]};
      end
      default: begin
        base = sgn ? {{20{field[11]}}, field[11:0]} : {20'h00000, field[11:0]};
      end
    endcase
    // Scale of three is never asked for; top bits simply fall off
    value = base << shift;
  end

endmodule // cifd_ext

// ### core/cifd_dec.v
// Instruction format decoder: splits a 16-bit word into its operand fields
`timescale 1ns/1ps

module cifd_dec (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        sys_rst,
  // Fetch side
  input  wire        fetch_valid,
  input  wire [15:0] fetch_instr,
  input  wire [3:0]  fetch_fmt,
  input  wire [2:0]  fetch_var,
  input  wire [1:0]  fetch_size,
  // Decoded instruction
  output reg         dec_valid,
  output reg  [3:0]  dec_fmt,
  output reg  [15:0] dec_opcode,
  output reg  [3:0]  dec_dst_idx,
  output reg         dec_dst_use,
  output reg  [3:0]  dec_dst_mode,
  output reg  [3:0]  dec_src_idx,
  output reg         dec_src_use,
  output reg  [3:0]  dec_src_mode,
  output reg  [11:0] dec_disp_raw,
  output reg  [31:0] dec_disp,
  output reg  [31:0] dec_imm,
  output reg         dec_mac_dest,
  output reg         dec_bad_fmt
);
`include "cifd_consts.vh"

  // ****************************************
  // Functions
  // ****************************************
  // Bits of the word that are operand fields read as zero in the opcode
  function [15:0] op_mask;
    input [3:0] fmt;
    begin
      case (fmt)
        `CIFD_FMT_ZERO: op_mask = `CIFD_MASK_NONE;
        `CIFD_FMT_N:    op_mask = `CIFD_MASK_HI;
        `CIFD_FMT_M:    op_mask = `CIFD_MASK_HI;
        `CIFD_FMT_NM:   op_mask = `CIFD_MASK_HIMID;
        `CIFD_FMT_MD:   op_mask = `CIFD_MASK_MIDLO;
        `CIFD_FMT_ND4:  op_mask = `CIFD_MASK_MIDLO;
        `CIFD_FMT_NMD:  op_mask = `CIFD_MASK_ALL12;
        `CIFD_FMT_D:    op_mask = `CIFD_MASK_LO8;
        `CIFD_FMT_D12:  op_mask = `CIFD_MASK_ALL12;
        `CIFD_FMT_ND8:  op_mask = `CIFD_MASK_HILO;
        `CIFD_FMT_I:    op_mask = `CIFD_MASK_LO8;
        `CIFD_FMT_NI:   op_mask = `CIFD_MASK_HILO;
        default:        op_mask = `CIFD_MASK_NONE;
      endcase
    end
  endfunction

  // Scale of a data access; an undefined size is treated as byte
  function [1:0] size_shift;
    input [1:0] size;
    begin
      case (size)
        `CIFD_SZ_WORD: size_shift = 2'h1;
        `CIFD_SZ_LONG: size_shift = 2'h2;
        default:       size_shift = 2'h0;
      endcase
    end
  endfunction

  // ****************************************
  // Field slices
  // ****************************************
  wire [3:0] fld_hi;
  wire [3:0] fld_mid;

  assign fld_hi  = fetch_instr[`CIFD_HI_LSB +: 4];
  assign fld_mid = fetch_instr[`CIFD_MID_LSB +: 4];

  // ****************************************
  // Combinational decode
  // ****************************************
  reg  [3:0]  dst_idx_nxt;
  reg         dst_use_nxt;
  reg  [3:0]  dst_mode_nxt;
  reg  [3:0]  src_idx_nxt;
  reg         src_use_nxt;
  reg  [3:0]  src_mode_nxt;
  reg  [11:0] disp_fld;
  reg  [1:0]  disp_w;
  reg         disp_sgn;
  reg  [1:0]  disp_sh;
  reg  [11:0] imm_fld;
  reg         imm_sgn;
  reg  [1:0]  imm_sh;
  reg         mac_nxt;
  reg         bad_nxt;
  wire [31:0] disp_ext;
  wire [31:0] imm_ext;

  always @* begin
    dst_idx_nxt  = `CIFD_REG_ZERO;
    dst_use_nxt  = 1'b0;
    dst_mode_nxt = `CIFD_AM_NONE;
    src_idx_nxt  = `CIFD_REG_ZERO;
    src_use_nxt  = 1'b0;
    src_mode_nxt = `CIFD_AM_NONE;
    disp_fld     = 12'h000;
    disp_w       = `CIFD_W4;
    disp_sgn     = 1'b0;
    disp_sh      = size_shift(fetch_size);
    imm_fld      = 12'h000;
    imm_sgn      = 1'b0;
    imm_sh       = 2'h0;
    mac_nxt      = 1'b0;
    bad_nxt      = 1'b0;
    case (fetch_fmt)
      `CIFD_FMT_ZERO: begin
        // No operand fields at all
        bad_nxt = 1'b0;
      end
      `CIFD_FMT_N: begin
        dst_idx_nxt  = fld_hi;
        dst_use_nxt  = 1'b1;
        dst_mode_nxt = `CIFD_AM_DIRECT;
        if (fetch_var == 3'h1) begin
          src_mode_nxt = `CIFD_AM_CTRL;
        end else if (fetch_var == 3'h2) begin
          src_mode_nxt = `CIFD_AM_CTRL;
          dst_mode_nxt = `CIFD_AM_PREDEC;
        end
      end
      `CIFD_FMT_M: begin
        src_idx_nxt = fld_hi;
        src_use_nxt = 1'b1;
        case (fetch_var)
          3'h0: begin
            src_mode_nxt = `CIFD_AM_DIRECT;
            dst_mode_nxt = `CIFD_AM_CTRL;
          end
          3'h1: begin
            src_mode_nxt = `CIFD_AM_POSTINC;
            dst_mode_nxt = `CIFD_AM_CTRL;
          end
          3'h2: begin
            // Jump target: no destination operand
            src_mode_nxt = `CIFD_AM_DIRECT;
          end
          default: begin
            src_mode_nxt = `CIFD_AM_PC_REL;
          end
        endcase
      end
      `CIFD_FMT_NM: begin
        dst_idx_nxt  = fld_hi;
        src_idx_nxt  = fld_mid;
        dst_use_nxt  = 1'b1;
        src_use_nxt  = 1'b1;
        src_mode_nxt = `CIFD_AM_DIRECT;
        case (fetch_var)
          3'h0: dst_mode_nxt = `CIFD_AM_DIRECT;
          3'h1: dst_mode_nxt = `CIFD_AM_IND;
          3'h2: begin
            // Both fields read memory; the high field is a source here
            src_mode_nxt = `CIFD_AM_POSTINC;
            dst_mode_nxt = `CIFD_AM_MAC;
            mac_nxt      = 1'b1;
          end
          3'h3: begin
            src_mode_nxt = `CIFD_AM_POSTINC;
            dst_mode_nxt = `CIFD_AM_DIRECT;
          end
          3'h4: dst_mode_nxt = `CIFD_AM_PREDEC;
          3'h5: dst_mode_nxt = `CIFD_AM_IDX_R0;
          default: begin
            bad_nxt      = 1'b1;
            dst_mode_nxt = `CIFD_AM_NONE;
          end
        endcase
      end
      `CIFD_FMT_MD: begin
        src_idx_nxt  = fld_mid;
        src_use_nxt  = 1'b1;
        src_mode_nxt = `CIFD_AM_DISP;
        dst_idx_nxt  = `CIFD_REG_ZERO;
        dst_use_nxt  = 1'b1;
        dst_mode_nxt = `CIFD_AM_DIRECT;
        disp_fld     = {8'h00, fetch_instr[3:0]};
      end
      `CIFD_FMT_ND4: begin
        dst_idx_nxt  = fld_mid;
        dst_use_nxt  = 1'b1;
        dst_mode_nxt = `CIFD_AM_DISP;
        src_idx_nxt  = `CIFD_REG_ZERO;
        src_use_nxt  = 1'b1;
        src_mode_nxt = `CIFD_AM_DIRECT;
        disp_fld     = {8'h00, fetch_instr[3:0]};
      end
      `CIFD_FMT_NMD: begin
        dst_idx_nxt = fld_hi;
        src_idx_nxt = fld_mid;
        dst_use_nxt = 1'b1;
        src_use_nxt = 1'b1;
        disp_fld    = {8'h00, fetch_instr[3:0]};
        // Variant 1 is a load, anything else a store
        if (fetch_var == 3'h1) begin
          src_mode_nxt = `CIFD_AM_DISP;
          dst_mode_nxt = `CIFD_AM_DIRECT;
        end else begin
          src_mode_nxt = `CIFD_AM_DIRECT;
          dst_mode_nxt = `CIFD_AM_DISP;
        end
      end
      `CIFD_FMT_D: begin
        disp_fld = {4'h0, fetch_instr[7:0]};
        disp_w   = `CIFD_W8;
        case (fetch_var)
          3'h0: begin
            src_mode_nxt = `CIFD_AM_GBR_DSP;
            dst_use_nxt  = 1'b1;
            dst_mode_nxt = `CIFD_AM_DIRECT;
          end
          3'h1: begin
            src_use_nxt  = 1'b1;
            src_mode_nxt = `CIFD_AM_DIRECT;
            dst_mode_nxt = `CIFD_AM_GBR_DSP;
          end
          3'h2: begin
            src_mode_nxt = `CIFD_AM_PC_DISP;
            dst_use_nxt  = 1'b1;
            dst_mode_nxt = `CIFD_AM_DIRECT;
          end
          default: begin
            src_mode_nxt = `CIFD_AM_PC_REL;
            disp_sgn     = 1'b1;
            disp_sh      = `CIFD_SH_BRANCH;
          end
        endcase
      end
      `CIFD_FMT_D12: begin
        disp_fld     = fetch_instr[11:0];
        disp_w       = `CIFD_W12;
        src_mode_nxt = `CIFD_AM_PC_REL;
        disp_sgn     = 1'b1;
        disp_sh      = `CIFD_SH_BRANCH;
      end
      `CIFD_FMT_ND8: begin
        dst_idx_nxt  = fld_hi;
        dst_use_nxt  = 1'b1;
        dst_mode_nxt = `CIFD_AM_DIRECT;
        src_mode_nxt = `CIFD_AM_PC_DISP;
        disp_fld     = {4'h0, fetch_instr[7:0]};
        disp_w       = `CIFD_W8;
      end
      `CIFD_FMT_I: begin
        imm_fld      = {4'h0, fetch_instr[7:0]};
        src_mode_nxt = `CIFD_AM_IMM;
        case (fetch_var)
          3'h0: dst_mode_nxt = `CIFD_AM_GBR_R0;
          3'h1: begin
            dst_use_nxt  = 1'b1;
            dst_mode_nxt = `CIFD_AM_DIRECT;
          end
          3'h2: begin
            // Arithmetic use of register zero takes a signed byte
            dst_use_nxt  = 1'b1;
            dst_mode_nxt = `CIFD_AM_DIRECT;
            imm_sgn      = 1'b1;
          end
          default: begin
            imm_sh = `CIFD_SH_TRAP;
          end
        endcase
      end
      `CIFD_FMT_NI: begin
        dst_idx_nxt  = fld_hi;
        dst_use_nxt  = 1'b1;
        dst_mode_nxt = `CIFD_AM_DIRECT;
        src_mode_nxt = `CIFD_AM_IMM;
        imm_fld      = {4'h0, fetch_instr[7:0]};
        imm_sgn      = 1'b1;
      end
      default: begin
        bad_nxt = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Extension and scaling
  // ****************************************
  // Disp path: zero-extended data offsets, signed doubled branches
  cifd_ext u_disp_ext (
    .field (disp_fld),
    .width (disp_w),
    .sgn   (disp_sgn),
    .shift (disp_sh),
    .value (disp_ext)
  );

  // Immediate path is never scaled except for the trap number
  cifd_ext u_imm_ext (
    .field (imm_fld),
    .width (`CIFD_W8),
    .sgn   (imm_sgn),
    .shift (imm_sh),
    .value (imm_ext)
  );

  // ****************************************
  // Output stage
  // ****************************************
  // One cycle of latency buys outputs free of decode glitches
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_valid    <= 1'b0;
      dec_fmt      <= `CIFD_FMT_ZERO;
      dec_opcode   <= `CIFD_RST_WORD;
      dec_dst_idx  <= `CIFD_REG_ZERO;
      dec_dst_use  <= 1'b0;
      dec_dst_mode <= `CIFD_AM_NONE;
      dec_src_idx  <= `CIFD_REG_ZERO;
      dec_src_use  <= 1'b0;
      dec_src_mode <= `CIFD_AM_NONE;
      dec_disp_raw <= 12'h000;
      dec_disp     <= `CIFD_RST_VAL;
      dec_imm      <= `CIFD_RST_VAL;
      dec_mac_dest <= 1'b0;
      dec_bad_fmt  <= 1'b0;
    end else begin
      dec_valid    <= fetch_valid;
      dec_fmt      <= fetch_fmt;
      dec_opcode   <= fetch_instr & op_mask(fetch_fmt);
      dec_dst_idx  <= dst_idx_nxt;
      dec_dst_use  <= dst_use_nxt;
      dec_dst_mode <= dst_mode_nxt;
      dec_src_idx  <= src_idx_nxt;
      dec_src_use  <= src_use_nxt;
      dec_src_mode <= src_mode_nxt;
      dec_disp_raw <= disp_fld;
      dec_disp     <= disp_ext;
      dec_imm      <= imm_ext;
      dec_mac_dest <= mac_nxt;
      dec_bad_fmt  <= fetch_valid & bad_nxt;
    end
  end

endmodule // cifd_dec

// ### tb/cifd_fetch_model.sv
// Fetch stage model that presents words to the decoder
`timescale 1ns/1ps

module cifd_fetch_model (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        sys_rst,
  // Words queued by the bench
  input  wire        req_valid,
  input  wire [15:0] req_instr,
  input  wire [3:0]  req_fmt,
  input  wire [2:0]  req_var,
  input  wire [1:0]  req_size,
  // Decoder fetch side
  output reg         fetch_valid,
  output reg  [15:0] fetch_instr,
  output reg  [3:0]  fetch_fmt,
  output reg  [2:0]  fetch_var,
  output reg  [1:0]  fetch_size
);
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {fetch_valid, fetch_instr, fetch_fmt, fetch_var, fetch_size} <= 26'h0;
    end else if (req_valid) begin
      {fetch_valid, fetch_instr} <= {1'b1, req_instr};
      {fetch_fmt, fetch_var, fetch_size} <= {req_fmt, req_var, req_size};
    end else begin
      // Bubble: bus keeps toggling so stale words never look valid
      fetch_valid <= 1'b0;
      {fetch_instr, fetch_fmt, fetch_var, fetch_size} <=
        ~{fetch_instr, fetch_fmt, fetch_var, fetch_size};
    end
  end
endmodule // cifd_fetch_model

// ### tb/cifd_dec_monitor.sv
// Concurrent checks on the instruction format decoder ports
`timescale 1ns/1ps

module cifd_dec_monitor (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        sys_rst,
  // Fetch side
  input  wire        fetch_valid,
  input  wire [15:0] fetch_instr,
  input  wire [3:0]  fetch_fmt,
  input  wire [2:0]  fetch_var,
  // Decoded instruction
  input  wire [15:0] dec_opcode,
  input  wire [3:0]  dec_dst_idx,
  input  wire        dec_dst_use,
  input  wire [3:0]  dec_src_idx,
  input  wire        dec_src_use,
  input  wire [3:0]  dec_src_mode,
  input  wire [11:0] dec_disp_raw,
  input  wire [31:0] dec_disp,
  input  wire [31:0] dec_imm,
  input  wire        dec_mac_dest,
  input  wire        dec_bad_fmt
);
  // ****************************************
  // Helpers
  // ****************************************
  // First edge after reset still shows reset values
  reg        live_r;
  reg [15:0] ir_r;
  reg [3:0]  fm_r;
  reg [2:0]  vr_r;
  reg        vl_r;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) live_r <= 1'b0;
    else live_r <= 1'b1;
  end
  always @(posedge sys_clk) begin
    {vl_r, ir_r, fm_r, vr_r} <= {fetch_valid, fetch_instr, fetch_fmt, fetch_var};
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Checks
  // ****************************************
  AST_ZERO: assert property (fetch_fmt == 4'h0 |=> dec_opcode == ir_r
    && !dec_dst_use && !dec_src_use && dec_disp == 32'h0) else $error("zero format field");
  AST_N: assert property (fetch_fmt == 4'h1 |=> dec_dst_idx == ir_r[11:8]
    && dec_dst_use && !dec_src_use) else $error("n format destination");
  AST_M: assert property (fetch_fmt == 4'h2 |=> dec_src_idx == ir_r[11:8]
    && dec_src_use && !dec_dst_use) else $error("m format source");
  AST_NM: assert property (fetch_fmt == 4'h3 && fetch_var < 3'h6 |=>
    dec_dst_idx == ir_r[11:8] && dec_src_idx == ir_r[7:4] && dec_opcode == (ir_r & 16'hf00f))
    else $error("nm format fields");
  AST_MAC: assert property (live_r && dec_mac_dest |->
    dec_src_mode == 4'h3 && fm_r == 4'h3 && vr_r == 3'h2) else $error("mac destination");
  AST_MD: assert property (fetch_fmt == 4'h4 |=> dec_src_idx == ir_r[7:4]
    && dec_dst_idx == 4'h0 && dec_disp_raw == {8'h00, ir_r[3:0]}) else $error("md fields");
  AST_ND4: assert property (fetch_fmt == 4'h5 |=> dec_dst_idx == ir_r[7:4]
    && dec_src_idx == 4'h0) else $error("nd4 fields");
  AST_BRA: assert property (fetch_fmt == 4'h8 |=>
    dec_disp == {{19{ir_r[11]}}, ir_r[11:0], 1'b0}) else $error("long branch disp");
  AST_TRAP: assert property (fetch_fmt == 4'ha && fetch_var > 3'h2 |=>
    dec_imm == {22'h0, ir_r[7:0], 2'b00}) else $error("trap immediate");
  AST_NI: assert property (fetch_fmt == 4'hb |=> dec_dst_idx == ir_r[11:8]
    && dec_imm == {{24{ir_r[7]}}, ir_r[7:0]}) else $error("ni immediate");
  AST_BAD: assert property (live_r |-> dec_bad_fmt ==
    (vl_r && (fm_r > 4'hb || (fm_r == 4'h3 && vr_r > 3'h5)))) else $error("bad format flag");
endmodule // cifd_dec_monitor

bind cifd_dec cifd_dec_monitor u_mon (.sys_clk, .sys_rst, .fetch_valid, .fetch_instr,
  .fetch_fmt, .fetch_var, .dec_opcode, .dec_dst_idx, .dec_dst_use, .dec_src_idx,
  .dec_src_use, .dec_src_mode, .dec_disp_raw, .dec_disp, .dec_imm, .dec_mac_dest,
  .dec_bad_fmt);

// ### tb/tb_cifd_dec.sv
// Self-checking bench for the instruction format decoder
`timescale 1ns/1ps

module tb_cifd_dec;
  // ****************************************
  // Signals
  // ****************************************
  reg          sys_clk, sys_rst, req_valid;
  reg  [15:0]  req_instr;
  reg  [3:0]   req_fmt;
  reg  [2:0]   req_var;
  reg  [1:0]   req_size;
  wire         fetch_valid, dec_valid, dec_dst_use, dec_src_use, dec_mac_dest, dec_bad_fmt;
  wire [15:0]  fetch_instr, dec_opcode;
  wire [3:0]   fetch_fmt, dec_fmt, dec_dst_idx, dec_dst_mode, dec_src_idx, dec_src_mode;
  wire [2:0]   fetch_var;
  wire [1:0]   fetch_size;
  wire [11:0]  dec_disp_raw;
  wire [31:0]  dec_disp, dec_imm;
  reg  [115:0] exp_q [$];
  reg  [115:0] e;
  reg  [31:0]  r;
  integer      n_fail, comparisons, f, v, k;
  wire [115:0] got = {dec_fmt, dec_opcode, dec_dst_idx, dec_dst_use, dec_dst_mode,
    dec_src_idx, dec_src_use, dec_src_mode, dec_mac_dest, dec_bad_fmt, dec_disp_raw,
    dec_disp, dec_imm};

  cifd_fetch_model u_fetch (.sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_instr(req_instr), .req_fmt(req_fmt), .req_var(req_var), .req_size(req_size),
    .fetch_valid(fetch_valid), .fetch_instr(fetch_instr), .fetch_fmt(fetch_fmt),
    .fetch_var(fetch_var), .fetch_size(fetch_size));
  cifd_dec u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .fetch_valid(fetch_valid),
    .fetch_instr(fetch_instr), .fetch_fmt(fetch_fmt), .fetch_var(fetch_var),
    .fetch_size(fetch_size), .dec_valid(dec_valid), .dec_fmt(dec_fmt),
    .dec_opcode(dec_opcode), .dec_dst_idx(dec_dst_idx), .dec_dst_use(dec_dst_use),
    .dec_dst_mode(dec_dst_mode), .dec_src_idx(dec_src_idx), .dec_src_use(dec_src_use),
    .dec_src_mode(dec_src_mode), .dec_disp_raw(dec_disp_raw), .dec_disp(dec_disp),
    .dec_imm(dec_imm), .dec_mac_dest(dec_mac_dest), .dec_bad_fmt(dec_bad_fmt));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Expected decode
  // ****************************************
  function automatic [115:0] ref_dec(input [15:0] w, input [3:0] f, input [2:0] v,
                                     input [1:0] s);
    reg [15:0] op;
    reg [3:0]  di, dm, si, sm;
    reg        du, su, mac, bad;
    reg [11:0] raw;
    reg [31:0] dp, im;
    reg [1:0]  sc;
    begin
      op = w & 16'hf000;
      {di, dm, si, sm, du, su, mac, bad, raw, dp, im} = '0;
      sc = (s == 2'h3) ? 2'h0 : s;
      case (f)
        4'h0: op = w;
        4'h1: begin
          op = w & 16'hf0ff; di = w[11:8]; du = 1; dm = (v == 2) ? 4'h4 : 4'h1;
          // Variants above two fall back to a plain destination
          sm = (v == 1 || v == 2) ? 4'hb : 4'h0;
        end
        4'h2: begin
          op = w & 16'hf0ff; si = w[11:8]; su = 1; dm = (v < 2) ? 4'hb : 4'h0;
          sm = (v == 1) ? 4'h3 : (v > 2) ? 4'ha : 4'h1;
        end
        4'h3: begin
          op = w & 16'hf00f; di = w[11:8]; si = w[7:4]; du = 1; su = 1; mac = (v == 2);
          sm = (v == 2 || v == 3) ? 4'h3 : 4'h1;
          case (v)
            3'h0, 3'h3: dm = 4'h1;
            3'h1: dm = 4'h2;
            3'h2: dm = 4'hd;
            3'h4: dm = 4'h4;
            // Variants six and seven are refused: no destination mode
            default: {dm, bad} = (v == 5) ? 5'h0a : 5'h01;
          endcase
        end
        4'h4, 4'h5: begin
          op = w & 16'hff00; raw = w[3:0]; dp = w[3:0] << sc; du = 1; su = 1;
          if (f == 4'h4) {si, sm, dm} = {w[7:4], 8'h61};
          else {di, dm, sm} = {w[7:4], 8'h61};
        end
        4'h6: begin
          di = w[11:8]; si = w[7:4]; du = 1; su = 1; raw = w[3:0]; dp = w[3:0] << sc;
          {sm, dm} = (v == 1) ? 8'h61 : 8'h16;
        end
        4'h7: begin
          op = w & 16'hff00; raw = w[7:0]; dp = w[7:0] << sc;
          case (v)
            3'h0: {sm, dm, du} = 9'h0e3;
            3'h1: {sm, su, dm} = 9'h037;
            3'h2: {sm, dm, du} = 9'h123;
            default: {sm, dp} = {4'ha, {23{w[7]}}, w[7:0], 1'b0};
          endcase
        end
        4'h8: {raw, sm, dp} = {w[11:0], 4'ha, {19{w[11]}}, w[11:0], 1'b0};
        4'h9: begin
          {di, du, dm, sm, raw} = {w[11:8], 9'h119, 4'h0, w[7:0]};
          dp = w[7:0] << sc;
        end
        4'ha: begin
          op = w & 16'hff00; sm = 4'hc; im = w[7:0];
          if (v == 0) dm = 4'h8;
          else if (v < 3) {du, dm} = 5'h11;
          if (v == 2) im = {{24{w[7]}}, w[7:0]};
          if (v > 2) im = w[7:0] << 2;
        end
        4'hb: {di, du, dm, sm, im} = {w[11:8], 9'h11c, {24{w[7]}}, w[7:0]};
        default: {op, bad} = {w, 1'b1};
      endcase
      ref_dec = {f, op, di, du, dm, si, su, sm, mac, bad, raw, dp, im};
    end
  endfunction

  // ****************************************
  // Driver and scoreboard
  // ****************************************
  task send(input [15:0] w, input [3:0] f, input [2:0] v, input [1:0] s);
    begin
      @(posedge sys_clk);
      {req_valid, req_instr, req_fmt, req_var, req_size} <= {1'b1, w, f, v, s};
      exp_q.push_back(ref_dec(w, f, v, s));
    end
  endtask

  task idle(input integer n);
    begin
      repeat (n) begin
        @(posedge sys_clk);
        req_valid <= 1'b0;
      end
    end
  endtask

  task give_verdict;
    begin
      // A decode that never came out would otherwise go unnoticed
      if (exp_q.size() != 0) begin
        n_fail = n_fail + 1;
        $display("[FAIL] pending results exp 0 got %0d", exp_q.size());
      end
      $display("Counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // One word in, one decode out, in order
  always @(posedge sys_clk) begin
    #1;
    if (dec_valid === 1'b1 && exp_q.size() == 0) begin
      n_fail = n_fail + 1;
      $display("[FAIL] dec_valid exp 0 got 1");
    end else if (dec_valid === 1'b1) begin
      e = exp_q.pop_front();
      comparisons = comparisons + 2;
      if (got[115:76] !== e[115:76]) begin
        n_fail = n_fail + 1;
        $display("[FAIL] operand fields exp %h got %h", e[115:76], got[115:76]);
      end
      if (got[75:0] !== e[75:0]) begin
        n_fail = n_fail + 1;
        $display("[FAIL] disp and imm exp %h got %h", e[75:0], got[75:0]);
      end
    end
  end

  initial begin
    #20000;
    n_fail = n_fail + 1;
    give_verdict;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {n_fail, comparisons} = 0;
    {sys_rst, req_valid, req_instr, req_fmt, req_var, req_size} = {2'b10, 25'h0};
    r = $urandom(32'h06b5);
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    send(16'h1234, 4'h6, 3'h1, 2'h2);
    send(16'h0800, 4'h8, 3'h0, 2'h0);
    // Every format and variant, random word then sign boundary, back to back
    for (f = 0; f < 16; f = f + 1) begin
      for (v = 0; v < 8; v = v + 1) begin
        r = $urandom;
        send(r[15:0], f[3:0], v[2:0], r[17:16]);
        send(v[0] ? 16'hffff : 16'h0080, f[3:0], v[2:0], v[2:1]);
      end
    end
    idle(3);
    // Reset in mid-run, then random traffic with bubbles
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    idle(2);
    sys_rst <= 1'b0;
    for (k = 0; k < 200; k = k + 1) begin
      r = $urandom;
      send(r[15:0], r[19:16], r[22:20], r[24:23]);
      if (r[31:29] == 3'h0) idle(1);
    end
    idle(3);
    give_verdict;
  end
endmodule // tb_cifd_dec
